/* hdl/ictp_port.sv */
// Two-wire configuration target port: link engine, crossings and receive FIFO
`timescale 1ns/100ps

module ictp_port
	import ictp_pkg::*;
#(
	parameter int FIFO_DEPTH = ICTP_FIFO_D
) (
	// System clock and reset
	input  wire logic                   CLOCK,
	input  wire logic                   RST,
	// Link sampling clock
	input  wire logic                   LINK_CLK,
	// Serial clock pin
	input  wire logic                   SCL_IN,
	output wire logic                   SCL_OUT,
	output wire logic                   SCL_OE,
	// Serial data pin
	input  wire logic                   SDA_IN,
	output wire logic                   SDA_OUT,
	output wire logic                   SDA_OE,
	// Address select pins
	input  wire logic [ICTP_SEL_W-1:0]  ADDR_SEL,
	// Received write bytes
	output wire logic [ICTP_BYTE_W-1:0] RX_DATA,
	output wire logic                   RX_VALID,
	input  wire logic                   RX_READY,
	// Bytes for read transfers
	input  wire logic [ICTP_BYTE_W-1:0] TX_DATA,
	input  wire logic                   TX_VALID,
	output wire logic                   TX_READY,
	// Status
	output wire logic                   ADDRESSED
);

	// ======================================================================
	// Link domain declarations
	ictp_state_t           state;
	logic                  scl_m, scl_s, scl_d;
	logic                  sda_m, sda_s, sda_d;
	logic [ICTP_SEL_W-1:0] sel_m, sel_s;
	logic                  rst_m, link_rst;
	logic                  rx_ack_m, rx_ack_s;
	logic                  tx_tog_m, tx_tog_s;
	logic [2:0]            cnt;
	logic [7:0]            shreg;
	logic                  ph;
	logic                  rd;
	logic                  fill;
	logic                  ack_ok;
	logic                  sda_pull;
	logic [7:0]            rx_word;
	logic                  rx_tog;
	logic                  tx_taken;
	logic                  addressed_l;
	logic                  scl_rise, scl_fall;
	logic                  start_c, stop_c;
	logic                  rx_busy;
	logic                  tx_avail;
	logic [7:0]            next_byte;
	logic [7:0]            in_byte;

	// ======================================================================
	// System domain declarations
	logic                  rx_tog_m, rx_tog_s, rx_tog_d;
	logic                  rx_ack;
	logic [7:0]            pend;
	logic                  pend_v;
	logic                  tx_tog;
	logic [7:0]            tx_slot;
	logic                  taken_m, taken_s;
	logic                  tx_full;
	logic                  adr_m, adr_s;

	ictp_stream_if #(.W(ICTP_BYTE_W)) fifo_in ();
	ictp_stream_if #(.W(ICTP_BYTE_W)) fifo_out ();

	// ======================================================================
	// Pins
	// Clock line is never driven, so no wait state is forced
	assign SCL_OUT = 1'b0;
	assign SCL_OE  = 1'b0;
	// Open drain data line: only ever pulled low
	assign SDA_OUT = 1'b0;
	assign SDA_OE  = sda_pull;

	// ======================================================================
	// Link domain synchronisers
	// Reset carried into the link domain
	always_ff @(posedge LINK_CLK) begin
		rst_m    <= RST;
		link_rst <= rst_m;
	end

	// Pin and select synchronisers, two stages before any logic
	always_ff @(posedge LINK_CLK) begin
		scl_m    <= SCL_IN;
		scl_s    <= scl_m;
		scl_d    <= scl_s;
		sda_m    <= SDA_IN;
		sda_s    <= sda_m;
		sda_d    <= sda_s;
		sel_m    <= ADDR_SEL;
		sel_s    <= sel_m;
	end

	// Handshake toggles coming from the system domain
	always_ff @(posedge LINK_CLK) begin
		rx_ack_m <= rx_ack;
		rx_ack_s <= rx_ack_m;
		tx_tog_m <= tx_tog;
		tx_tog_s <= tx_tog_m;
	end

	// Bus events seen on the synchronised lines
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
	assign in_byte  = {shreg[6:0], sda_s};
	assign rx_busy  = rx_tog ^ rx_ack_s;
	assign tx_avail = tx_tog_s ^ tx_taken;
	// Slot holds still while offered, so reading it here is safe
	assign next_byte = tx_avail ? tx_slot : ICTP_IDLE_BYTE;

	// Link states in which a matched transfer is under way
	function automatic logic ictp_in_xfer(input ictp_state_t s);
		return (s == ICTP_WR_DATA) || (s == ICTP_ACK) ||
			(s == ICTP_RD_DATA) || (s == ICTP_RD_MACK);
	endfunction

	// Addressed flag for the system side
	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			addressed_l <= 1'b0;
		end else begin
			addressed_l <= ictp_in_xfer(state);
		end
	end

	// ======================================================================
	// Link engine
	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			state    <= ICTP_IDLE;
			cnt      <= '0;
			shreg    <= '0;
			ph       <= 1'b0;
			rd       <= 1'b0;
			fill     <= 1'b0;
			ack_ok   <= 1'b0;
			sda_pull <= 1'b0;
			rx_word  <= '0;
			rx_tog   <= 1'b0;
			tx_taken <= 1'b0;
		end else if (stop_c) begin
			// Stop ends any transfer and frees the line
			state    <= ICTP_IDLE;
			sda_pull <= 1'b0;
			ph       <= 1'b0;
		end else if (start_c) begin
			// Start, or repeated start, opens an address byte
			state    <= ICTP_ADDR;
			cnt      <= '0;
			sda_pull <= 1'b0;
			ph       <= 1'b0;
		end else begin
			unique case (state)
				ICTP_IDLE, ICTP_IGNORE: begin
					sda_pull <= 1'b0;
				end
				ICTP_ADDR: begin
					if (scl_rise) begin
						shreg <= in_byte;
						cnt   <= cnt + 1'b1;
						if (cnt == ICTP_BIT_LAST) begin
							// Seven address bits then direction bit
							if (shreg[6:0] == ictp_own_addr(sel_s)) begin
								state  <= ICTP_ACK;
								ack_ok <= 1'b1;
								rd     <= (sda_s == ICTP_RW_READ);
								fill   <= 1'b1;
							end else begin
								state <= ICTP_IGNORE;
							end
						end
					end
				end
				ICTP_WR_DATA: begin
					if (scl_rise) begin
						shreg <= in_byte;
						cnt   <= cnt + 1'b1;
						if (cnt == ICTP_BIT_LAST) begin
							state <= ICTP_ACK;
							if (fill) begin
								// First byte after address is dropped
								fill   <= 1'b0;
								ack_ok <= 1'b1;
							end else if (!rx_busy) begin
								rx_word <= in_byte;
								rx_tog  <= ~rx_tog;
								ack_ok  <= 1'b1;
							end else begin
								// Receive path full: refuse the byte
								ack_ok <= 1'b0;
							end
						end
					end
				end
				ICTP_ACK: begin
					if (scl_fall) begin
						if (!ph) begin
							// Hold low through the acknowledge high period
							ph       <= 1'b1;
							sda_pull <= ack_ok;
						end else begin
							ph <= 1'b0;
							if (!ack_ok) begin
								state    <= ICTP_IGNORE;
								sda_pull <= 1'b0;
							end else if (rd) begin
								// Present first read bit right away
								state    <= ICTP_RD_DATA;
								shreg    <= next_byte;
								sda_pull <= ~next_byte[7];
								tx_taken <= tx_taken ^ tx_avail;
							end else begin
								state    <= ICTP_WR_DATA;
								sda_pull <= 1'b0;
							end
						end
					end
				end
				ICTP_RD_DATA: begin
					if (scl_fall) begin
						cnt <= cnt + 1'b1;
						if (cnt == ICTP_BIT_LAST) begin
							// Release for the master's acknowledge
							state    <= ICTP_RD_MACK;
							sda_pull <= 1'b0;
						end else begin
							shreg    <= {shreg[6:0], 1'b1};
							sda_pull <= ~shreg[6];
						end
					end
				end
				ICTP_RD_MACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							// Not acknowledged: last byte, wait for stop
							state <= ICTP_IGNORE;
						end else begin
							ph <= 1'b1;
						end
					end else if (scl_fall && ph) begin
						ph       <= 1'b0;
						state    <= ICTP_RD_DATA;
						shreg    <= next_byte;
						sda_pull <= ~next_byte[7];
						tx_taken <= tx_taken ^ tx_avail;
					end
				end
			endcase
		end
	end

	// ======================================================================
	// System domain synchronisers
	// Handshake toggles coming from the link domain
	always_ff @(posedge CLOCK) begin
		rx_tog_m <= rx_tog;
		rx_tog_s <= rx_tog_m;
		taken_m  <= tx_taken;
		taken_s  <= taken_m;
	end

	// Addressed status, a slow level, two stages
	always_ff @(posedge CLOCK) begin
		adr_m    <= addressed_l;
		adr_s    <= adr_m;
	end

	// Edge tracker for the receive toggle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rx_tog_d <= 1'b0;
		end else begin
			rx_tog_d <= rx_tog_s;
		end
	end

	// Receive handshake: hold byte until the FIFO takes it
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pend   <= '0;
			pend_v <= 1'b0;
			rx_ack <= 1'b0;
		end else if (rx_tog_s ^ rx_tog_d) begin
			pend   <= rx_word;
			pend_v <= 1'b1;
		end else if (pend_v && fifo_in.ready) begin
			pend_v <= 1'b0;
			rx_ack <= ~rx_ack;
		end
	end

	assign fifo_in.data  = pend;
	assign fifo_in.valid = pend_v;

	// ======================================================================
	// Receive FIFO
	// Absorbs write bytes while the sink is slow

	ictp_fifo #(
		.W     (ICTP_BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk   (CLOCK),
		.rst   (RST),
		.in_s  (fifo_in),
		.out_s (fifo_out)
	);

	assign RX_DATA        = fifo_out.data;
	assign RX_VALID       = fifo_out.valid;
	assign fifo_out.ready = RX_READY;

	// Transmit slot offered to the link by a toggle
	assign tx_full  = tx_tog ^ taken_s;
	assign TX_READY = ~tx_full;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			tx_tog  <= 1'b0;
			tx_slot <= '0;
		end else if (TX_VALID && !tx_full) begin
			tx_slot <= TX_DATA;
			tx_tog  <= ~tx_tog;
		end
	end

	// ======================================================================
	// Status
	// Level that follows the link engine after the crossing
	assign ADDRESSED = adr_s;

endmodule

/* hdl/ictp_pkg.sv */
// Constants and types of the two-wire configuration target port
// ==========================================================================
// Operation
// - After start, compare next byte with address
// - On match, serve read or write per direction
// - Acknowledge each byte except last read byte (write bytes are refused while the receive path is full)
// - First write data byte is discarded filler
// - Every byte shifts most significant bit first
// - Data falling while clock high is start
// - Data rising while clock high is stop
// - Seven-bit address, three bits from pins
// - Never hold the clock line low
// - Pull data low through acknowledge clock pulse
package ictp_pkg;

	// ======================================================================
	// Address layout
	localparam int             ICTP_ADDR_W    = 7;
	localparam int             ICTP_SEL_W     = 3;
	localparam logic [6:0]     ICTP_ADDR_BASE = 7'h60; // Fixed bits, select bits zero
	localparam int             ICTP_SEL0_POS  = 0;
	localparam int             ICTP_SEL1_POS  = 1;
	localparam int             ICTP_SEL2_POS  = 4;
	localparam logic           ICTP_RW_READ   = 1'h1;

	// ======================================================================
	// Byte framing
	localparam int             ICTP_BYTE_W    = 8;
	localparam logic [2:0]     ICTP_BIT_LAST  = 3'h7;
	localparam logic [7:0]     ICTP_IDLE_BYTE = 8'hff; // Sent when no read byte is queued
	localparam int             ICTP_FIFO_D    = 16;

	// ======================================================================
	// Link engine states
	typedef enum logic [2:0] {
		ICTP_IDLE,
		ICTP_ADDR,
		ICTP_IGNORE,
		ICTP_WR_DATA,
		ICTP_ACK,
		ICTP_RD_DATA,
		ICTP_RD_MACK
	} ictp_state_t;

	// Build the own address from the select pins
	function automatic logic [6:0] ictp_own_addr(input logic [2:0] sel);
		logic [6:0] a;
		a = ICTP_ADDR_BASE;
		a[ICTP_SEL0_POS] = sel[0];
		a[ICTP_SEL1_POS] = sel[1];
		a[ICTP_SEL2_POS] = sel[2];
		return a;
	endfunction

endpackage

/* hdl/ictp_stream_if.sv */
// Valid and ready byte stream between the port and its FIFO
`timescale 1ns/100ps

interface ictp_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

/* hdl/ictp_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps

module ictp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic     clk,
	input wire logic     rst,
	// Streams
	ictp_stream_if.snk   in_s,
	ictp_stream_if.src   out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic         full;
	logic         empty;

	// Honest full and empty from the wrap bit
	assign empty       = (wr_ptr == rd_ptr);
	assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_s.ready  = ~full;
	assign out_s.valid = ~empty;
	assign out_s.data  = mem[rd_ptr[AW-1:0]];

	// Storage write
	always_ff @(posedge clk) begin
		if (in_s.valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_s.data;
		end
	end

	// Write pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
		end else if (in_s.valid && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ptr <= '0;
		end else if (out_s.ready && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

/* verif/ictp_port_asserts.sv */
// Concurrent checks on the pins of the two-wire target port
`timescale 1ns/100ps

module ictp_port_asserts #(
	parameter int FIFO_DEPTH = 16
) (
	// Clocks and reset
	input wire logic       CLOCK,
	input wire logic       RST,
	input wire logic       LINK_CLK,
	// Serial pins
	input wire logic       SCL_IN,
	input wire logic       SCL_OE,
	input wire logic       SDA_IN,
	input wire logic       SDA_OUT,
	input wire logic       SDA_OE,
	// Streams and status
	input wire logic [7:0] RX_DATA,
	input wire logic       RX_VALID,
	input wire logic       RX_READY,
	input wire logic       TX_VALID,
	input wire logic       TX_READY,
	input wire logic       ADDRESSED
);
	// ====
	// Bus conditions seen on the system clock
	sequence s_start;
		SCL_IN && $fell(SDA_IN);
	endsequence
	sequence s_stop;
		SCL_IN && $rose(SDA_IN);
	endsequence
	sequence s_unaddressed;
		##[1:12] !ADDRESSED;
	endsequence

	// ====
	// Pin behaviour on the link clock
	a_scl_never_held: assert property (@(posedge LINK_CLK) disable iff (RST) !SCL_OE)
		else $error("serial clock driven");
	a_oe_drives_low: assert property (@(posedge LINK_CLK) disable iff (RST) SDA_OE |-> !SDA_OUT)
		else $error("data pin driven high");
	a_oe_moves_low: assert property (@(posedge LINK_CLK) disable iff (RST) $changed(SDA_OE) |-> !SCL_IN)
		else $error("data drive changed while clock high");

	// ====
	// Framing and streams on the system clock
	a_start_clears: assert property (@(posedge CLOCK) disable iff (RST) s_start |-> s_unaddressed)
		else $error("start did not reopen address phase");
	a_stop_clears: assert property (@(posedge CLOCK) disable iff (RST) s_stop |-> s_unaddressed)
		else $error("stop did not end transfer");
	a_rx_holds: assert property (@(posedge CLOCK) disable iff (RST)
		RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA)) else $error("receive byte lost");
	a_tx_takes: assert property (@(posedge CLOCK) disable iff (RST)
		TX_VALID && TX_READY |=> !TX_READY) else $error("read slot not taken");
	a_reset_state: assert property (@(posedge CLOCK) disable iff (RST)
		$fell(RST) |-> !RX_VALID && TX_READY && !ADDRESSED) else $error("bad state after reset");
endmodule

bind ictp_port ictp_port_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_ictp_port_asserts (
	.CLOCK, .RST, .LINK_CLK, .SCL_IN, .SCL_OE, .SDA_IN, .SDA_OUT, .SDA_OE,
	.RX_DATA, .RX_VALID, .RX_READY, .TX_VALID, .TX_READY, .ADDRESSED);

/* verif/ictp_master_model.sv */
// Behavioural two-wire bus master facing the target port
`timescale 1ns/100ps

module ictp_master_model #(
	parameter int HALF = 100
) (
	// Bus lines
	output logic      scl,
	output logic      sda_o,
	input  wire logic sda
);
	// Idle bus with both lines released
	initial begin
		scl = 1'h1;
		sda_o = 1'h1;
	end
	// Start or repeated start
	task automatic start();
		sda_o = 1'h1;
		#HALF scl = 1'h1;
		#HALF sda_o = 1'h0;
		#HALF scl = 1'h0;
	endtask
	// Stop, then the clock stands still
	task automatic stop();
		sda_o = 1'h0;
		#HALF scl = 1'h1;
		#HALF sda_o = 1'h1;
		#HALF;
	endtask
	// One byte and its acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_o = d[i];
			#HALF scl = 1'h1;
			q[i] = sda;
			#HALF scl = 1'h0;
		end
		sda_o = ack_in;
		#HALF scl = 1'h1;
		ack = sda;
		#HALF scl = 1'h0;
	endtask
endmodule

/* verif/ictp_port_tb.sv */
// Self-checking bench for the two-wire configuration target port
`timescale 1ns/100ps

module ictp_port_tb;
	// ====
	// Signals
	logic        clock, link_clk, rst, scl, sda_o, scl_oe, sda_oe, sda_out, scl_out, k;
	logic        rx_valid, rx_ready, tx_valid, tx_ready, addressed;
	logic [2:0]  addr_sel;
	logic [6:0]  own;
	logic [7:0]  rx_data, tx_data, b, q;
	logic [7:0]  expq[$];
	logic [31:0] seed = 32'h12;
	int          miscompares = 0;
	int          comparisons = 0;
	wire         scl_w = scl & ~scl_oe; // Pulled-up lines, wired-AND
	wire         sda_w = sda_o & ~sda_oe;

	ictp_port i_ictp_port (
		.CLOCK(clock), .RST(rst), .LINK_CLK(link_clk), .SCL_IN(scl_w), .SCL_OUT(scl_out),
		.SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ADDR_SEL(addr_sel), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
		.TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .ADDRESSED(addressed));
	ictp_master_model i_master (.scl(scl), .sda_o(sda_o), .sda(sda_w));

	// Clocks, the link one unrelated in phase
	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	initial begin
		link_clk = 1'h0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// ====
	// Helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [6:0] own_addr(input logic [2:0] s);
		return {2'h3, s[2], 2'h0, s[1:0]};
	endfunction
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", n, exp, seen);
			miscompares++;
		end
	endtask
	task automatic results();
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic a, input logic ea);
		i_master.xfer(d, a, q, k);
		check("ack", {7'h0, k}, {7'h0, ea});
	endtask
	// Queue one read byte
	task automatic push(input logic [7:0] d);
		@(negedge clock);
		tx_data = d;
		tx_valid = 1'h1;
		while (tx_ready !== 1'h1) @(negedge clock);
		@(negedge clock);
		tx_valid = 1'h0;
	endtask
	// Pop and compare every expected byte, then expect an empty FIFO
	task automatic drain();
		while (expq.size() > 0) begin
			@(negedge clock);
			rx_ready = (rx_valid === 1'h1);
			if (rx_ready) check("rx data", rx_data, expq.pop_front());
		end
		@(negedge clock);
		check("rx empty", {7'h0, rx_valid}, 8'h00);
		rx_ready = 1'h0;
	endtask

	// ====
	// Scenarios
	initial begin
		rst = 1'h1;
		rx_ready = 1'h0;
		tx_valid = 1'h0;
		tx_data = 8'h00;
		b = rnd();
		addr_sel = b[2:0];
		own = own_addr(addr_sel);
		repeat (12) @(negedge clock);
		rst = 1'h0;
		repeat (4) @(negedge clock);
		// Write with filler byte and bit-order corners
		i_master.start();
		byte_io({own, 1'h0}, 1'h1, 1'h0);
		for (int i = 0; i < 6; i++) begin
			b = (i == 1) ? 8'h80 : (i == 2) ? 8'h01 : rnd();
			byte_io(b, 1'h1, 1'h0);
			if (i > 0) expq.push_back(b);
		end
		i_master.stop();
		drain();
		// Foreign address ignored until a repeated start begins a read
		b = rnd();
		push(b);
		i_master.start();
		byte_io({own ^ 7'h04, 1'h1}, 1'h1, 1'h1);
		byte_io(8'h00, 1'h1, 1'h1);
		check("addressed", {7'h0, addressed}, 8'h00);
		i_master.start();
		byte_io({own, 1'h1}, 1'h1, 1'h0);
		check("addressed", {7'h0, addressed}, 8'h01);
		i_master.xfer(8'hff, 1'h0, q, k);
		check("read", q, b);
		i_master.xfer(8'hff, 1'h1, q, k);
		check("empty read", q, 8'hff);
		i_master.stop();
		// Stalled sink: FIFO fills, late bytes refused
		i_master.start();
		byte_io({own, 1'h0}, 1'h1, 1'h0);
		byte_io(rnd(), 1'h1, 1'h0);
		for (int i = 0; i < 20; i++) begin
			b = rnd();
			i_master.xfer(b, 1'h1, q, k);
			if (i < 16 || i == 19) check("fill ack", {7'h0, k}, {7'h0, i == 19});
			if (k === 1'h0) expq.push_back(b);
		end
		i_master.stop();
		drain();
		results();
	end

	// Watchdog well beyond the expected run
	initial begin
		#300000;
		miscompares++;
		results();
	end
endmodule
